// ==== hdl/ivw_defines.svh ====
/*
  Constants for the interrupt vector and wake-up map: vector slot addresses,
  IRQ numbers and map geometry. Assumes a 24-bit program address space.
*/
`ifndef IVW_DEFINES_SVH
`define IVW_DEFINES_SVH
`define IVW_ADDR_W       24
`define IVW_NUM_IRQ      25
`define IVW_IRQ_W        5
`define IVW_RESET_VEC    24'h008000
`define IVW_TRAP_VEC     24'h008004
`define IVW_IRQ_BASE     24'h008008
`define IVW_SLOT_SHIFT   2
`define IVW_LAST_SLOT    24'h00807c
// Bit n set: IRQ n is a real source (8, 9, 17, 18 unused)
`define IVW_USED_MASK    25'h1f9fcff
// Bit n set: IRQ n wakes from halt (ports A..E, serial peripheral, two-wire bus)
`define IVW_HALT_WAKE    25'h00804f8
// Bit n set: IRQ n wakes from active-halt (adds auto-wakeup on IRQ 1)
`define IVW_AHALT_WAKE   25'h00804fa
`define IVW_IRQ_TLI      5'h00
`define IVW_IRQ_AWU      5'h01
`define IVW_IRQ_PA       5'h03
`define IVW_IRQ_PB       5'h04
`define IVW_IRQ_PC       5'h05
`define IVW_IRQ_PD       5'h06
`define IVW_IRQ_PE       5'h07
`define IVW_IRQ_SER2_RX  5'h15
`define IVW_IRQ_CONV     5'h16
`define IVW_IRQ_SPI      5'h0a
`define IVW_IRQ_TWO_WIRE 5'h13
// Vector slots of the sources that carry their own mapping rule
`define IVW_VEC_TLI      24'h008008
`define IVW_VEC_AWU      24'h00800c
`define IVW_VEC_PA       24'h008014
`define IVW_VEC_PB       24'h008018
`define IVW_VEC_PC       24'h00801c
`define IVW_VEC_PD       24'h008020
`define IVW_VEC_PE       24'h008024
`define IVW_VEC_SER2_RX  24'h00805c
`define IVW_VEC_CONV     24'h008060
// Bit n set: IRQ n is a reserved slot (8, 9, 17, 18)
`define IVW_UNUSED_MASK  25'h0060300
// Bit n set: timers, serial transmit and flash, which never wake the chip
`define IVW_QUIET_MASK   25'h191f800
`endif

// ==== hdl/ivw_pkg.sv ====
/*
  Types for the interrupt vector and wake-up map.
  Assumes ivw_defines.svh is on the include path.
*/
`include "ivw_defines.svh"
package ivw_pkg;
  typedef enum logic [2:0] {
    IVW_RUN   = 3'h1,
    IVW_HALT  = 3'h2,
    IVW_AHALT = 3'h4
  } ivw_mode_t;

  // Vector answer handed to the core
  typedef struct packed {
    logic                    valid;
    logic [`IVW_IRQ_W-1:0]   irq;
    logic [`IVW_ADDR_W-1:0]  vector;
  } ivw_vec_t;
endpackage : ivw_pkg

// ==== hdl/ivw_map.sv ====
/*
  Interrupt vector and wake-up map: maps peripheral request lines onto IRQ
  numbers and 4-byte vector slots, and raises wake-up from halt/active-halt.
  Assumes requests are levels on clk_i, and the core supplies the power mode.
*/
// Operation
// - The top-level external interrupt is IRQ 0 at 0x8008 and wakes from neither low-power mode.
// - The auto-wakeup source is IRQ 1 at 0x800C and wakes from active-halt only.
// - Port A edge group is IRQ 3 at 0x8014 and wakes from halt and active-halt.
// - Port B edge group is IRQ 4 at 0x8018 and wakes from halt and active-halt.
// - Port C edge group is IRQ 5 at 0x801C and wakes from halt and active-halt.
// - Port D edge group is IRQ 6 at 0x8020 and wakes from halt and active-halt.
// - Port E edge group is IRQ 7 at 0x8024 and wakes from halt and active-halt.
// - Second serial port receive-full is IRQ 21 at 0x805C and wakes from neither mode.
// - Converter end-of-conversion and watchdog merge onto IRQ 22 at 0x8060 with no wake-up.
`timescale 1ns/1ps
`include "ivw_defines.svh"
module ivw_map #(
  parameter int NUM_IRQ = `IVW_NUM_IRQ
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic [NUM_IRQ-1:0]       irq_req_i,
  input  wire logic                     conv_eoc_i,
  input  wire logic                     conv_awd_i,
  input  wire logic                     trap_i,
  input  wire ivw_pkg::ivw_mode_t       mode_i,
  output ivw_pkg::ivw_vec_t             vec_o,
  output logic                          wake_o,
  output logic [`IVW_ADDR_W-1:0]        reset_vec_o
);
  // Requests: converter lines merge into their IRQ, unused slots forced off
  logic [NUM_IRQ-1:0] merged;
  logic [NUM_IRQ-1:0] live;
  logic [NUM_IRQ-1:0] halt_wake;
  logic [NUM_IRQ-1:0] ahalt_wake;
  logic [NUM_IRQ-1:0] conv_bit;
  assign conv_bit   = (conv_eoc_i | conv_awd_i) ? (NUM_IRQ'(1) << `IVW_IRQ_CONV) : '0;
  assign merged     = irq_req_i | conv_bit;
  assign live       = merged & NUM_IRQ'(`IVW_USED_MASK);
  assign halt_wake  = live & NUM_IRQ'(`IVW_HALT_WAKE);
  assign ahalt_wake = live & NUM_IRQ'(`IVW_AHALT_WAKE);

  // Wake-up depends on the mode the core is sleeping in
  logic wake_nxt;
  assign wake_nxt = (mode_i == ivw_pkg::IVW_HALT)  ? |halt_wake :
                    (mode_i == ivw_pkg::IVW_AHALT) ? |ahalt_wake : 1'b0;

  // Lowest pending IRQ number is presented; no priority scheme beyond that
  logic [`IVW_IRQ_W-1:0] sel_irq;
  logic                  any_live;
  always_comb
  begin
    sel_irq = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (live[i])
        sel_irq = `IVW_IRQ_W'(i);
    end
  end
  assign any_live = |live;

  // Slot address: trap outranks IRQs; IRQ n at base plus four times n
  ivw_pkg::ivw_vec_t vec_nxt;
  assign vec_nxt.valid  = trap_i | any_live;
  assign vec_nxt.irq    = trap_i ? '0 : sel_irq;
  assign vec_nxt.vector = trap_i ? `IVW_TRAP_VEC :
                          any_live ? (`IVW_IRQ_BASE +
                            (`IVW_ADDR_W'(sel_irq) << `IVW_SLOT_SHIFT)) : '0;

  // Registered outputs so the core sees a clean answer
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      vec_o       <= '0;
      wake_o      <= 1'b0;
      reset_vec_o <= `IVW_RESET_VEC;
    end
    else
    begin
      vec_o       <= vec_nxt;
      wake_o      <= wake_nxt;
      reset_vec_o <= `IVW_RESET_VEC;
    end
  end

  // Checks: each source alone must land in its own slot with its own wake-up
  // behaviour; expected slots are the fixed constants, not the adder above
  logic sleeping;
  assign sleeping = (mode_i == ivw_pkg::IVW_HALT) || (mode_i == ivw_pkg::IVW_AHALT);

  // Top-level interrupt owns the first IRQ slot
  property p_tli_vec;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && irq_req_i[`IVW_IRQ_TLI]) |=> (vec_o.vector == `IVW_VEC_TLI);
  endproperty
  a_tli_vec: assert property (p_tli_vec)
    else $error("top-level irq vector wrong");

  // Top-level interrupt alone never wakes the chip
  property p_tli_nowake;
    @(posedge clk_i) disable iff (!nrst_i)
    (merged == NUM_IRQ'(1)) |=> !wake_o;
  endproperty
  a_tli_nowake: assert property (p_tli_nowake)
    else $error("top-level irq woke chip");

  // Auto-wakeup wakes from active-halt
  property p_awu_ahalt;
    @(posedge clk_i) disable iff (!nrst_i)
    (live == (NUM_IRQ'(1) << `IVW_IRQ_AWU) && mode_i == ivw_pkg::IVW_AHALT) |=> wake_o;
  endproperty
  a_awu_ahalt: assert property (p_awu_ahalt)
    else $error("auto-wakeup missed active-halt");

  // Auto-wakeup must not wake from full halt
  property p_awu_halt;
    @(posedge clk_i) disable iff (!nrst_i)
    (live == (NUM_IRQ'(1) << `IVW_IRQ_AWU) && mode_i == ivw_pkg::IVW_HALT) |=> !wake_o;
  endproperty
  a_awu_halt: assert property (p_awu_halt)
    else $error("auto-wakeup woke from halt");

  // Auto-wakeup slot
  property p_awu_vec;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && live == (NUM_IRQ'(1) << `IVW_IRQ_AWU)) |=> (vec_o.vector == `IVW_VEC_AWU);
  endproperty
  a_awu_vec: assert property (p_awu_vec)
    else $error("auto-wakeup vector wrong");

  // Port A edge group wakes from either low-power mode
  property p_port_a_wake;
    @(posedge clk_i) disable iff (!nrst_i)
    (live[`IVW_IRQ_PA] && sleeping) |=> wake_o;
  endproperty
  a_port_a_wake: assert property (p_port_a_wake)
    else $error("port A did not wake");

  // Port A edge group slot
  property p_port_a_vec;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && live == (NUM_IRQ'(1) << `IVW_IRQ_PA)) |=> (vec_o.vector == `IVW_VEC_PA);
  endproperty
  a_port_a_vec: assert property (p_port_a_vec)
    else $error("port A vector wrong");

  // Port B edge group: slot and wake-up
  property p_port_b;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && sleeping && live == (NUM_IRQ'(1) << `IVW_IRQ_PB)) |=>
      (vec_o.vector == `IVW_VEC_PB && wake_o);
  endproperty
  a_port_b: assert property (p_port_b)
    else $error("port B map wrong");

  // Port C edge group: slot and wake-up
  property p_port_c;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && sleeping && live == (NUM_IRQ'(1) << `IVW_IRQ_PC)) |=>
      (vec_o.vector == `IVW_VEC_PC && wake_o);
  endproperty
  a_port_c: assert property (p_port_c)
    else $error("port C map wrong");

  // Port D edge group: slot and wake-up
  property p_port_d;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && sleeping && live == (NUM_IRQ'(1) << `IVW_IRQ_PD)) |=>
      (vec_o.vector == `IVW_VEC_PD && wake_o);
  endproperty
  a_port_d: assert property (p_port_d)
    else $error("port D map wrong");

  // Port E edge group: slot and IRQ number
  property p_port_e;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && live == (NUM_IRQ'(1) << `IVW_IRQ_PE)) |=>
      (vec_o.vector == `IVW_VEC_PE && vec_o.irq == `IVW_IRQ_PE);
  endproperty
  a_port_e: assert property (p_port_e)
    else $error("port E vector wrong");

  // Second serial port receive-full: own slot, never a wake source
  property p_ser_rx;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && live == (NUM_IRQ'(1) << `IVW_IRQ_SER2_RX)) |=>
      (!wake_o && vec_o.vector == `IVW_VEC_SER2_RX);
  endproperty
  a_ser_rx: assert property (p_ser_rx)
    else $error("serial rx map wrong");

  // Either converter request alone lands on the shared slot, no wake-up
  property p_conv;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && irq_req_i == '0 && (conv_eoc_i || conv_awd_i)) |=>
      (vec_o.irq == `IVW_IRQ_CONV && vec_o.vector == `IVW_VEC_CONV && !wake_o);
  endproperty
  a_conv: assert property (p_conv)
    else $error("converter map wrong");

  // Reserved lines alone (or nothing at all) give no vector
  property p_unused;
    @(posedge clk_i) disable iff (!nrst_i)
    (!trap_i && (merged & ~NUM_IRQ'(`IVW_UNUSED_MASK)) == '0) |=> !vec_o.valid;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused irq produced vector");

  // Reset slot is a constant once out of reset
  property p_reset_vec;
    @(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> (reset_vec_o == `IVW_RESET_VEC);
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector wrong");

  // Software trap outranks every IRQ and reports IRQ zero
  property p_trap;
    @(posedge clk_i) disable iff (!nrst_i)
    trap_i |=> (vec_o.valid && vec_o.irq == '0 && vec_o.vector == `IVW_TRAP_VEC);
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap vector wrong");

  // Serial peripheral wakes from either low-power mode
  property p_spi_wake;
    @(posedge clk_i) disable iff (!nrst_i)
    (live[`IVW_IRQ_SPI] && sleeping) |=> wake_o;
  endproperty
  a_spi_wake: assert property (p_spi_wake)
    else $error("serial peripheral did not wake");

  // Two-wire bus wakes from either low-power mode
  property p_two_wire_wake;
    @(posedge clk_i) disable iff (!nrst_i)
    (live[`IVW_IRQ_TWO_WIRE] && sleeping) |=> wake_o;
  endproperty
  a_two_wire_wake: assert property (p_two_wire_wake)
    else $error("two-wire bus did not wake");

  // Timers, serial transmit and flash never wake the chip
  property p_quiet;
    @(posedge clk_i) disable iff (!nrst_i)
    ((live & ~NUM_IRQ'(`IVW_QUIET_MASK)) == '0) |=> !wake_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("non-wake source woke chip");
endmodule : ivw_map

// ==== verif/ivw_core_model.sv ====
/* Core-side partner: fetches the vector slot on each valid answer.
   Assumes vec_i is the registered answer of the map. */
`timescale 1ns/1ps
module ivw_core_model (
  input  wire logic              clk_i,
  input  wire ivw_pkg::ivw_vec_t vec_i,
  output logic [23:0]            fetch_o
);
  // Holds the last fetched slot, as a core would between interrupts
  always_ff @(posedge clk_i)
  begin
    if (vec_i.valid) fetch_o <= vec_i.vector;
  end
endmodule : ivw_core_model

// ==== verif/tb.sv ====
/* Self-checking bench for the vector and wake-up map.
   Assumes the package and the core model are compiled first. */
`timescale 1ns/1ps
module tb;
  logic               clk_i = 1'b0;
  logic               nrst_i = 1'b0;
  logic [24:0]        req = '0;
  logic               eoc = 1'b0;
  logic               awd = 1'b0;
  logic               trap = 1'b0;
  ivw_pkg::ivw_mode_t mode = ivw_pkg::IVW_RUN;
  ivw_pkg::ivw_vec_t  vec;
  logic               wake;
  logic [23:0]        rvec;
  logic [23:0]        fetch;
  int                 miscompares = 0;
  int                 checked = 0;
  ivw_map uut (.clk_i(clk_i), .nrst_i(nrst_i), .irq_req_i(req), .conv_eoc_i(eoc),
    .conv_awd_i(awd), .trap_i(trap), .mode_i(mode), .vec_o(vec), .wake_o(wake),
    .reset_vec_o(rvec));
  ivw_core_model core (.clk_i(clk_i), .vec_i(vec), .fetch_o(fetch));
  // 8 ns period
  always #4 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Answer lands one edge after the inputs, so check just after that edge
  task automatic step(input logic [24:0] r, input ivw_pkg::ivw_mode_t m, input logic t);
    req = r;
    mode = m;
    trap = t;
    @(posedge clk_i);
    #1;
  endtask : step
  // Every used IRQ alone, in each mode; slot is 0x8008 + 4n
  task automatic t_map();
    int n[21] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13, 14, 15, 16, 19, 20, 21, 22, 23, 24};
    bit hw[21] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0};
    bit aw[21] = '{0, 1, 0, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0};
    logic [23:0] slot;
    for (int i = 0; i < 21; i++)
    begin
      slot = 24'h008008 + 24'(4 * n[i]);
      step(25'h1 << n[i], ivw_pkg::IVW_HALT, 1'b0);
      chk("vec", {vec.valid, vec.irq, vec.vector}, {1'b1, 5'(n[i]), slot});
      chk("halt_wake", wake, hw[i]);
      step(25'h1 << n[i], ivw_pkg::IVW_AHALT, 1'b0);
      chk("ahalt_wake", wake, aw[i]);
      step(25'h1 << n[i], ivw_pkg::IVW_RUN, 1'b0);
      chk("run_wake", wake, 1'b0);
    end
  endtask : t_map
  // Both converter requests merge onto IRQ 22 with no wake-up
  task automatic t_conv();
    eoc = 1'b1;
    step('0, ivw_pkg::IVW_HALT, 1'b0);
    chk("eoc", {vec.valid, vec.irq, vec.vector, wake}, {1'b1, 5'h16, 24'h008060, 1'b0});
    eoc = 1'b0;
    awd = 1'b1;
    step('0, ivw_pkg::IVW_AHALT, 1'b0);
    chk("awd", {vec.valid, vec.irq, vec.vector, wake}, {1'b1, 5'h16, 24'h008060, 1'b0});
    awd = 1'b0;
  endtask : t_conv
  // Trap slot, unused lines ignored, reset slot, core fetch of the trap
  task automatic t_trap();
    chk("rst_vec", rvec, 24'h008000);
    step(25'h10, ivw_pkg::IVW_RUN, 1'b1);
    chk("trap", {vec.valid, vec.irq, vec.vector}, {1'b1, 5'h00, 24'h008004});
    step(25'h60300, ivw_pkg::IVW_HALT, 1'b0);
    chk("unused", {vec.valid, wake}, 2'b00);
    chk("fetch", fetch, 24'h008004);
  endtask : t_trap
  // Two sources at once: the lower number is presented; then a mid-run reset
  // must clear the answer while the requests are still standing
  task automatic t_prio_reset();
    step(25'h0200010, ivw_pkg::IVW_AHALT, 1'b0);
    chk("prio", {vec.valid, vec.irq, vec.vector, wake}, {1'b1, 5'h04, 24'h008018, 1'b1});
    nrst_i = 1'b0;
    #1;
    chk("rst_out", {vec.valid, vec.irq, vec.vector, wake}, 31'h0);
    chk("rst_rvec", rvec, 24'h008000);
    @(posedge clk_i);
    #1;
    chk("rst_hold", {vec.valid, wake}, 2'b00);
    nrst_i = 1'b1;
    step(25'h0200010, ivw_pkg::IVW_AHALT, 1'b0);
    chk("after_rst", {vec.valid, vec.irq, vec.vector, wake}, {1'b1, 5'h04, 24'h008018, 1'b1});
    step('0, ivw_pkg::IVW_RUN, 1'b0);
  endtask : t_prio_reset
  task automatic stop_test();
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Reset for 16 cycles, then the scenarios
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    t_trap();
    t_map();
    t_conv();
    t_prio_reset();
    stop_test();
  end
endmodule : tb
